// ==== src/process_data_bit_mapper.sv ====
// Status/control word mapping and port sub-slot data shaping with an AXI4-Lite register file
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pdm_consts.svh"

// Summary of operation
// - Mode 1: ports 8-5 high, 4-1 low
// - Mode 2: ports 4-1 high, 8-5 low
// - Mode 3: channel B high, A low
// - Mode 4: channel A high, B low
// - Default mode 2, mode 1 for older
// - Mode 5 follows per-channel user positions
// - High byte goes first, big-endian
// - Port n diagnostics on channel n
// - Invalid mixed-class positions ignored or inactive
// - Ports 1-8 in sub-slots 1.2-1.9
// - Input 1-33, output 1-32 bytes
// - Qualifier byte appended last in comm mode
// - Digital input: one byte, bit 0
// - Digital input mirrored into status word
// - Digital input carries no qualifier byte
// - Mapping mode leaves sub-slot data alone
// - Qualifier bits 0-3 read zero
// - Qualifier bit 4 shows port enabled
// - Qualifier bit 5 shows device communicating
// - Bit 6 fault, bit 7 data valid
// - Digital output driven from bit 0
// - Control word source ignores sub-slot bit
// - Status/control module: 2 in, 2 out
// - Each output has exactly one source
module process_data_bit_mapper #(
    parameter int ADDR_W = 8,             // AXI address width
    parameter bit NEWER_DESC = 1'b1        // Newer configuration description in use
) (
    input wire logic aclk,                // Process clock, 100 MHz
    input wire logic aresetn,             // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid,       // Write address valid
    output logic s_axi_awready,           // Write address ready
    input wire logic [31:0] s_axi_wdata,  // Write data
    input wire logic [3:0] s_axi_wstrb,   // Write byte enables
    input wire logic s_axi_wvalid,        // Write data valid
    output logic s_axi_wready,            // Write data ready
    output logic [1:0] s_axi_bresp,       // Write response
    output logic s_axi_bvalid,            // Write response valid
    input wire logic s_axi_bready,        // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid,       // Read address valid
    output logic s_axi_arready,           // Read address ready
    output logic [31:0] s_axi_rdata,      // Read data
    output logic [1:0] s_axi_rresp,       // Read response
    output logic s_axi_rvalid,            // Read data valid
    input wire logic s_axi_rready,        // Read data ready
    input wire logic [15:0] ctrl_word,    // Control word from controller
    output logic [7:0] status_byte_first, // Status high byte, lower address
    output logic [7:0] status_byte_second, // Status low byte, higher address
    input wire logic [7:0] port1_chan_a,  // Channel A pin states, port 1 in bit 0
    input wire logic [7:0] chan_b_in,     // Channel B pin states
    output logic [7:0] chan_a_out,        // Channel A output drive
    output logic [7:0] chan_b_out,        // Channel B output drive
    input wire logic [7:0] subslot_out_bit0, // Bit 0 of each sub-slot output byte 1
    input wire logic [7:0] device_communicating_flag, // Device in preoperate/operate
    input wire logic [7:0] port_fault_flag, // Error or warning per port
    input wire logic [7:0] process_data_valid_flag, // Device data valid
    input wire logic [7:0] port_diag_event, // Diagnostic condition per port
    output logic [7:0] diag_channel,      // Diagnostic channel n for port n
    output logic [63:0] port_qualifier_byte, // Qualifier byte per port
    output logic [7:0] qualifier_present, // Qualifier appended for the port
    output logic [63:0] subslot_in_byte1, // First input byte for digital input
    output logic [47:0] subslot_in_len,   // Input area length per port
    output logic [47:0] subslot_out_len   // Output area length per port
);
    // Parameter check; the register decode needs a full byte of address
    initial if (ADDR_W < 8 || ADDR_W > 32) $error("ADDR_W must lie between 8 and 32");

    // Configuration registers
    logic [2:0] map_mode_ff;       // Selected bit order
    logic a_src_ctrl_ff;           // Channel A outputs taken from control word
    logic [15:0] pmode_ff;         // Port modes
    logic [31:0] valid_ff;         // Valid input (low) and output (high) positions
    logic [63:0] umap_ff;          // Mode 5 word position per channel
    logic [63:0] ilen_ff;          // Requested input lengths
    logic [63:0] olen_ff;          // Requested output lengths
    // AXI state
    logic [ADDR_W-1:0] awaddr_ff;  // Held write address
    logic aw_held_ff;              // Write address captured
    logic [31:0] wdata_ff;         // Held write data
    logic [3:0] wstrb_ff;          // Held byte enables
    logic w_held_ff;               // Write data captured
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    // Output registers
    logic [15:0] status_ff;
    logic [7:0] a_out_ff;
    logic [7:0] b_out_ff;
    logic [7:0] diag_ff;
    logic [63:0] qual_ff;
    logic [7:0] qual_on_ff;
    logic [63:0] in_b1_ff;
    logic [47:0] ilen_out_ff;
    logic [47:0] olen_out_ff;
    // Combinational results
    logic [15:0] nxt_status;
    logic [15:0] ctrl_ch;          // Control bit per channel, index 2p+b
    logic [15:0] in_ch;            // Input state per channel, index 2p+b
    logic do_write;

    // Word position of channel idx (2*port+b) under a mapping mode
    function automatic logic [3:0] pos_of(input logic [2:0] mode, input logic [3:0] idx,
                                          input logic [63:0] umap);
        logic [2:0] p;
        logic b;
        p = idx[3:1];
        b = idx[0];
        unique case (mode)
            pdm_pkg::MAP_MODE2: pos_of = p[2] ? {1'b0, p[1:0], b} : {1'b1, p[1:0], b};
            pdm_pkg::MAP_MODE3: pos_of = {b, p};
            pdm_pkg::MAP_MODE4: pos_of = {~b, p};
            pdm_pkg::MAP_MODE5: pos_of = umap[4*idx +: 4];
            // mode 1, also used for unused codes
            default: pos_of = idx;
        endcase
    endfunction

    // Clamp a requested length into min..max
    function automatic logic [5:0] clamp_len(input logic [7:0] req, input logic [5:0] max);
        clamp_len = (req < {2'h0, `PDM_LEN_MIN}) ? `PDM_LEN_MIN :
                    (req > {2'h0, max}) ? max : req[5:0];
    endfunction

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction

    // Per-channel input states and decoded control bits
    genvar gc;
    for (gc = 0; gc < 16; gc++) begin : g_ch
        logic [3:0] pos;
        logic [1:0] pm;
        assign pos = pos_of(map_mode_ff, 4'(gc), umap_ff);
        assign pm = pmode_ff[2*(gc/2) +: 2];
        if (gc % 2 == 0) begin : g_a
            // channel A mirrored only in digital input mode
            assign in_ch[gc] = (pm == pdm_pkg::PM_DIN) & port1_chan_a[gc/2]
                               & valid_ff[gc];
        end else begin : g_b
            assign in_ch[gc] = chan_b_in[gc/2] & valid_ff[gc];
        end
        // invalid output positions have no effect
        assign ctrl_ch[gc] = ctrl_word[pos] & valid_ff[16+gc];
    end

    // Status word assembly; colliding user positions are ORed
    always_comb begin
        nxt_status = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (in_ch[i]) begin
                nxt_status[pos_of(map_mode_ff, i[3:0], umap_ff)] = 1'b1;
            end
        end
    end

    // high byte first; two status bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= 16'h0000;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Output drive per port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_out_ff <= 8'h00;
            b_out_ff <= 8'h00;
        end else begin
            for (int p = 0; p < 8; p++) begin
                // one source per channel A output, chosen by the source setting; channel B always from the control word
                if (pmode_ff[2*p +: 2] != pdm_pkg::PM_DOUT) begin
                    a_out_ff[p] <= 1'b0;
                // control word replaces sub-slot bit 0
                end else if (a_src_ctrl_ff) begin
                    a_out_ff[p] <= ctrl_ch[2*p];
                end else begin
                    // sub-slot bit 0 drives channel A
                    a_out_ff[p] <= subslot_out_bit0[p] & valid_ff[16+2*p];
                end
                b_out_ff[p] <= ctrl_ch[2*p+1];
            end
        end
    end

    // diagnostics of port n on channel n
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_ff <= 8'h00;
        end else begin
            diag_ff <= port_diag_event;
        end
    end

    // Sub-slot data shaping; index p is sub-slot 1.(p+2), independent of the mapping mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qual_ff <= 64'h0;
            qual_on_ff <= 8'h00;
            in_b1_ff <= 64'h0;
            ilen_out_ff <= 48'h0;
            olen_out_ff <= 48'h0;
        end else begin
            for (int p = 0; p < 8; p++) begin
                qual_ff[8*p +: 8] <= 8'h00;
                qual_ff[8*p+`PDM_Q_ENABLED] <= (pmode_ff[2*p +: 2] != pdm_pkg::PM_OFF);
                qual_ff[8*p+`PDM_Q_COMM] <= device_communicating_flag[p];
                qual_ff[8*p+`PDM_Q_FAULT] <= port_fault_flag[p];
                qual_ff[8*p+`PDM_Q_VALID] <= process_data_valid_flag[p];
                unique case (pmode_ff[2*p +: 2])
                    pdm_pkg::PM_COMM: begin
                        // clamped lengths, qualifier as last byte
                        qual_on_ff[p] <= 1'b1;
                        in_b1_ff[8*p +: 8] <= 8'h00;
                        ilen_out_ff[6*p +: 6] <= clamp_len(ilen_ff[8*p +: 8], `PDM_IN_LEN_MAX);
                        olen_out_ff[6*p +: 6] <= clamp_len(olen_ff[8*p +: 8], `PDM_OUT_LEN_MAX);
                    end
                    pdm_pkg::PM_DIN: begin
                        // single byte, state in bit 0, no qualifier
                        qual_on_ff[p] <= 1'b0;
                        in_b1_ff[8*p +: 8] <= {7'h00, port1_chan_a[p]};
                        ilen_out_ff[6*p +: 6] <= `PDM_LEN_MIN;
                        olen_out_ff[6*p +: 6] <= 6'h00;
                    end
                    pdm_pkg::PM_DOUT: begin
                        qual_on_ff[p] <= 1'b0;
                        in_b1_ff[8*p +: 8] <= 8'h00;
                        ilen_out_ff[6*p +: 6] <= 6'h00;
                        olen_out_ff[6*p +: 6] <= `PDM_LEN_MIN;
                    end
                    default: begin
                        // Port off: no data areas
                        qual_on_ff[p] <= 1'b0;
                        in_b1_ff[8*p +: 8] <= 8'h00;
                        ilen_out_ff[6*p +: 6] <= 6'h00;
                        olen_out_ff[6*p +: 6] <= 6'h00;
                    end
                endcase
            end
        end
    end

    // AXI write channel capture; address and data accepted in either order
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            // Reopen only after the response is taken, so one write is under way
            if (bvalid_ff && s_axi_bready) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `PDM_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            unique case (awaddr_ff[7:0])
                `PDM_CFG_OFS, `PDM_PMODE_OFS, `PDM_VALID_OFS, `PDM_UMAP0_OFS,
                `PDM_UMAP1_OFS, `PDM_ILEN0_OFS, `PDM_ILEN1_OFS, `PDM_OLEN0_OFS,
                `PDM_OLEN1_OFS, `PDM_STAT_OFS, `PDM_LIVE_OFS: bresp_ff <= `PDM_RESP_OKAY;
                default: bresp_ff <= `PDM_RESP_SLVERR;
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Register writes with byte enables; read-only words ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // default bit order depends on description age
            map_mode_ff <= NEWER_DESC ? pdm_pkg::MAP_MODE2 : pdm_pkg::MAP_MODE1;
            a_src_ctrl_ff <= 1'b0;
            pmode_ff <= `PDM_PMODE_RST;
            valid_ff <= `PDM_VALID_RST;
            umap_ff <= {`PDM_UMAP1_RST, `PDM_UMAP0_RST};
            ilen_ff <= {`PDM_LEN_RST, `PDM_LEN_RST};
            olen_ff <= {`PDM_LEN_RST, `PDM_LEN_RST};
        end else if (do_write && (awaddr_ff >> 8) == '0) begin
            unique case (awaddr_ff[7:0])
                `PDM_CFG_OFS: begin
                    if (wstrb_ff[0]) begin
                        map_mode_ff <= wdata_ff[2:0];
                    end
                    if (wstrb_ff[1]) begin
                        a_src_ctrl_ff <= wdata_ff[`PDM_CFG_ASRC_BIT];
                    end
                end
                `PDM_PMODE_OFS: pmode_ff <= 16'(merge({16'h0, pmode_ff}, wdata_ff, wstrb_ff));
                `PDM_VALID_OFS: valid_ff <= merge(valid_ff, wdata_ff, wstrb_ff);
                `PDM_UMAP0_OFS: umap_ff[31:0] <= merge(umap_ff[31:0], wdata_ff, wstrb_ff);
                `PDM_UMAP1_OFS: umap_ff[63:32] <= merge(umap_ff[63:32], wdata_ff, wstrb_ff);
                `PDM_ILEN0_OFS: ilen_ff[31:0] <= merge(ilen_ff[31:0], wdata_ff, wstrb_ff);
                `PDM_ILEN1_OFS: ilen_ff[63:32] <= merge(ilen_ff[63:32], wdata_ff, wstrb_ff);
                `PDM_OLEN0_OFS: olen_ff[31:0] <= merge(olen_ff[31:0], wdata_ff, wstrb_ff);
                `PDM_OLEN1_OFS: olen_ff[63:32] <= merge(olen_ff[63:32], wdata_ff, wstrb_ff);
                default: begin
                end
            endcase
        end
    end

    // Read channel: one cycle to answer, one read under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `PDM_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= `PDM_RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                `PDM_CFG_OFS: rdata_ff <= {23'h0, a_src_ctrl_ff, 5'h0, map_mode_ff};
                `PDM_PMODE_OFS: rdata_ff <= {16'h0, pmode_ff};
                `PDM_VALID_OFS: rdata_ff <= valid_ff;
                `PDM_UMAP0_OFS: rdata_ff <= umap_ff[31:0];
                `PDM_UMAP1_OFS: rdata_ff <= umap_ff[63:32];
                `PDM_ILEN0_OFS: rdata_ff <= ilen_ff[31:0];
                `PDM_ILEN1_OFS: rdata_ff <= ilen_ff[63:32];
                `PDM_OLEN0_OFS: rdata_ff <= olen_ff[31:0];
                `PDM_OLEN1_OFS: rdata_ff <= olen_ff[63:32];
                `PDM_STAT_OFS: rdata_ff <= {16'h0, status_ff};
                `PDM_LIVE_OFS: rdata_ff <= {8'h0, qual_on_ff, chan_b_in, port1_chan_a};
                default: begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= `PDM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Port connections, all from flip-flops
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // first byte is the high byte
    assign status_byte_first = status_ff[15:8];
    assign status_byte_second = status_ff[7:0];
    assign chan_a_out = a_out_ff;
    assign chan_b_out = b_out_ff;
    assign diag_channel = diag_ff;
    // port p data on output lane p
    assign port_qualifier_byte = qual_ff;
    assign qualifier_present = qual_on_ff;
    assign subslot_in_byte1 = in_b1_ff;
    assign subslot_in_len = ilen_out_ff;
    assign subslot_out_len = olen_out_ff;
endmodule
`default_nettype wire

// ==== src/pdm_consts.svh ====
// Offsets, field positions, reset values and limits of the process data bit mapper
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH
`define PDM_CFG_OFS 8'h00
`define PDM_PMODE_OFS 8'h04
`define PDM_VALID_OFS 8'h08
`define PDM_UMAP0_OFS 8'h0C
`define PDM_UMAP1_OFS 8'h10
`define PDM_ILEN0_OFS 8'h14
`define PDM_ILEN1_OFS 8'h18
`define PDM_OLEN0_OFS 8'h1C
`define PDM_OLEN1_OFS 8'h20
`define PDM_STAT_OFS 8'h24
`define PDM_LIVE_OFS 8'h28
`define PDM_CFG_ASRC_BIT 8
`define PDM_PMODE_RST 16'h5555
`define PDM_VALID_RST 32'hFFFFFFFF
`define PDM_UMAP0_RST 32'h76543210
`define PDM_UMAP1_RST 32'hFEDCBA98
`define PDM_LEN_RST 32'h01010101
`define PDM_IN_LEN_MAX 6'h21
`define PDM_OUT_LEN_MAX 6'h20
`define PDM_LEN_MIN 6'h01
`define PDM_Q_ENABLED 4
`define PDM_Q_COMM 5
`define PDM_Q_FAULT 6
`define PDM_Q_VALID 7
`define PDM_RESP_OKAY 2'h0
`define PDM_RESP_SLVERR 2'h2
`endif

// ==== src/pdm_pkg.sv ====
// Types shared by the process data bit mapper
package pdm_pkg;
    // Bit order of the status/control word
    typedef enum logic [2:0] {
        MAP_MODE1 = 3'h1,
        MAP_MODE2 = 3'h2,
        MAP_MODE3 = 3'h3,
        MAP_MODE4 = 3'h4,
        MAP_MODE5 = 3'h5
    } map_mode_t;
    // Per-port operating mode, two bits per port
    typedef enum logic [1:0] {
        PM_OFF = 2'h0,
        PM_COMM = 2'h1,
        PM_DIN = 2'h2,
        PM_DOUT = 2'h3
    } port_mode_t;
endpackage

// ==== verif/pdm_properties.sv ====
// Port checks for the process data bit mapper
`timescale 1ns/100ps
`default_nettype none
module pdm_properties (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, low
    input wire logic s_axi_awvalid, // Addr valid
    input wire logic s_axi_awready, // Addr ready
    input wire logic s_axi_wvalid, // Data valid
    input wire logic s_axi_wready, // Data ready
    input wire logic s_axi_bvalid, // Resp valid
    input wire logic [7:0] port_fault_flag, // Fault
    input wire logic [7:0] device_communicating_flag, // Comm
    input wire logic [7:0] process_data_valid_flag, // Valid
    input wire logic [7:0] port_diag_event, // Diag in
    input wire logic [7:0] diag_channel, // Diag out
    input wire logic [63:0] port_qualifier_byte, // Qualifiers
    input wire logic [7:0] qualifier_present, // Qualifier on
    input wire logic [63:0] subslot_in_byte1, // Input byte
    input wire logic [47:0] subslot_in_len // Input lengths
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken at one edge
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Both readies stay low for two cycles in a row
    sequence wr_busy;
        (!s_axi_awready && !s_axi_wready)[*2];
    endsequence
    a_diag_follow: assert property ($past(aresetn) |-> diag_channel == $past(port_diag_event))
        else $error("diag channel lags wrongly");
    a_qual_reserved: assert property ((port_qualifier_byte & 64'h0F0F0F0F0F0F0F0F) == 64'h0)
        else $error("qualifier low bits set");
    a_qual_enabled: assert property (qualifier_present[0] |-> port_qualifier_byte[4])
        else $error("enabled bit clear");
    a_qual_status: assert property ($past(aresetn) && qualifier_present[0] |->
        port_qualifier_byte[7:5] == {$past(process_data_valid_flag[0]),
        $past(port_fault_flag[0]), $past(device_communicating_flag[0])})
        else $error("qualifier flags wrong");
    a_din_single: assert property ((subslot_in_byte1 & 64'hFEFEFEFEFEFEFEFE) == 64'h0)
        else $error("input byte upper bits set");
    a_din_noqual: assert property (subslot_in_byte1[0] |-> !qualifier_present[0])
        else $error("qualifier on digital input");
    a_len_bound: assert property (qualifier_present[0] |-> subslot_in_len[5:0] <= 6'h21 && subslot_in_len[5:0] != 6'h0)
        else $error("input length out of range");
    a_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_write_busy: assert property (wr_both |=> wr_busy)
        else $error("ready during write");
endmodule
bind process_data_bit_mapper pdm_properties pdm_properties_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .port_fault_flag,
    .device_communicating_flag, .process_data_valid_flag, .port_diag_event, .diag_channel,
    .port_qualifier_byte, .qualifier_present, .subslot_in_byte1, .subslot_in_len);
`default_nettype wire

// ==== verif/plc_model.sv ====
// Controller model: control data out, status word in
`timescale 1ns/100ps
`default_nettype none
module plc_model (
    input wire logic aclk, // Clock
    input wire logic [7:0] status_byte_first, // First byte
    input wire logic [7:0] status_byte_second, // Second byte
    output logic [15:0] ctrl_word, // Control word
    output logic [7:0] subslot_out_bit0, // Output bits
    output logic [15:0] status_word // Status word
);
    // first byte is the high byte
    assign status_word = {status_byte_first, status_byte_second};
    initial ctrl_word = 16'h0;
    initial subslot_out_bit0 = 8'h0;
    // New cyclic output just after an edge
    task automatic send(input logic [15:0] c, input logic [7:0] o);
        @(posedge aclk);
        ctrl_word <= c;
        subslot_out_bit0 <= o;
    endtask
endmodule
`default_nettype wire

// ==== verif/process_data_bit_mapper_bench.sv ====
// Self-checking bench for the process data bit mapper
`timescale 1ns/100ps
`default_nettype none
`include "pdm_consts.svh"
module process_data_bit_mapper_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h0, ara = 8'h0, cha = 8'h0, chb = 8'h0, link_comm_mode = 8'h0, flt = 8'h0;
    logic [7:0] vld = 8'h0, dev = 8'h0, sf, ss, ao, bo, dgc, qp, ob;
    logic [31:0] wd = 32'h0, rdat;
    logic awr, wrr, bv, arr, rv;
    logic [1:0] br, rr;
    logic [15:0] cw, sw;
    logic [63:0] pq, ib;
    logic [47:0] il, ol;
    int errors = 0, total_checks = 0;
    always #5 aclk = ~aclk;
    process_data_bit_mapper process_data_bit_mapper_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .ctrl_word(cw), .status_byte_first(sf), .status_byte_second(ss),
        .port1_chan_a(cha), .chan_b_in(chb), .chan_a_out(ao), .chan_b_out(bo),
        .subslot_out_bit0(ob), .device_communicating_flag(link_comm_mode), .port_fault_flag(flt),
        .process_data_valid_flag(vld), .port_diag_event(dev), .diag_channel(dgc),
        .port_qualifier_byte(pq), .qualifier_present(qp), .subslot_in_byte1(ib),
        .subslot_in_len(il), .subslot_out_len(ol));
    plc_model plc_model_i (.aclk(aclk), .status_byte_first(sf), .status_byte_second(ss),
        .ctrl_word(cw), .subslot_out_bit0(ob), .status_word(sw));
    // Word bit of port p, channel b (1 = B) per mapping mode
    function automatic int pos(input int m, input int p, input int b);
        case (m)
            1: return 2 * p + b;
            2: return (2 * p + b + 8) % 16;
            3: return b ? 8 + p : p;
            default: return b ? p : 8 + p;
        endcase
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write; each half is released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        chk(br, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        chk(rdat, e);
        chk(rr, er);
    endtask
    task automatic t_map;
        logic [15:0] w;
        logic [63:0] b;
        cha <= 8'hA5;
        chb <= 8'h3C;
        wr(`PDM_PMODE_OFS, 32'hAAAA, `PDM_RESP_OKAY);
        for (int m = 1; m <= 4; m++) begin
            wr(`PDM_CFG_OFS, m, `PDM_RESP_OKAY);
            repeat (3) @(posedge aclk);
            w = 16'h0;
            b = 64'h0;
            for (int p = 0; p < 8; p++) begin
                w[pos(m, p, 0)] = cha[p];
                w[pos(m, p, 1)] = chb[p];
                b[8 * p] = cha[p];
            end
            chk(sw, w);
            chk(ib, b);
            chk(qp, 8'h0);
        end
        $display("mapping test done");
    endtask
    task automatic t_qual;
        logic [63:0] q;
        link_comm_mode <= 8'hF0;
        flt <= 8'hCC;
        vld <= 8'hAA;
        wr(`PDM_PMODE_OFS, 32'h5555, `PDM_RESP_OKAY);
        wr(`PDM_ILEN0_OFS, 32'h30303030, `PDM_RESP_OKAY);
        repeat (3) @(posedge aclk);
        for (int p = 0; p < 8; p++) q[8 * p +: 8] = {vld[p], flt[p], link_comm_mode[p], 5'h10};
        chk(pq, q);
        chk(qp, 8'hFF);
        chk(il, {{4{6'h01}}, {4{6'h21}}});
        chk(ol, {8{6'h01}});
        $display("qualifier test done");
    endtask
    task automatic t_dout;
        logic [15:0] c;
        logic [7:0] pa, pb;
        pa = 8'h96;
        pb = 8'h0F;
        c = 16'h0;
        for (int p = 0; p < 8; p++) c[pos(2, p, 0)] = pa[p];
        for (int p = 0; p < 8; p++) c[pos(2, p, 1)] = pb[p];
        dev <= 8'h81;
        wr(`PDM_PMODE_OFS, 32'hFFFF, `PDM_RESP_OKAY);
        plc_model_i.send(16'h0, 8'h5A);
        repeat (3) @(posedge aclk);
        chk(ao, 8'h5A);
        wr(`PDM_CFG_OFS, 32'h102, `PDM_RESP_OKAY);
        plc_model_i.send(c, 8'h69);
        repeat (3) @(posedge aclk);
        chk(ao, pa);
        chk(bo, pb);
        chk(dgc, 8'h81);
        $display("output test done");
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PDM_CFG_OFS, 32'h2, `PDM_RESP_OKAY);
        rd(`PDM_PMODE_OFS, 32'h5555, `PDM_RESP_OKAY);
        rd(8'h3C, 32'h0, `PDM_RESP_SLVERR);
        wr(8'h3C, 32'h1, `PDM_RESP_SLVERR);
        $display("reset test done");
        t_map();
        t_qual();
        t_dout();
        final_report();
    end
endmodule
`default_nettype wire
